//--- logic/awc_defs.svh
`ifndef AWC_DEFS_SVH
`define AWC_DEFS_SVH
`define AWC_ADDR_CTRL 8'he8
`define AWC_ADDR_CFG 8'hbc
`define AWC_ADDR_DATAH 8'hbe
`define AWC_ADDR_DATAL 8'hbd
`define AWC_ADDR_GTH 8'hc4
`define AWC_ADDR_GTL 8'hc3
`define AWC_ADDR_LTH 8'hc6
`define AWC_ADDR_LTL 8'hc5
`define AWC_ADDR_REF 8'hd1
`define AWC_RST_GTH 8'hff
`define AWC_RST_GTL 8'hff
`define AWC_RST_LTH 8'h00
`define AWC_RST_LTL 8'h00
`define AWC_RST_REF 8'h00
`define AWC_RST_CFG 8'hf8
`define AWC_RST_CTRL 8'h00
`define AWC_REF_MASK 8'h3f
`define AWC_ATTENUATION_SETUP_HI 8'h04
`define AWC_GAIN_UNITY 8'hfc
`define AWC_GAIN_HALF 8'h7c
`define AWC_SAR_CYCLES 5'h0d
`define AWC_FAST_EXTRA 5'h02
`define AWC_BIT_EN 7
`define AWC_BIT_DONE 5
`define AWC_BIT_BUSY 4
`define AWC_BIT_WIN 3
`define AWC_BIT_LJ 2
`define AWC_BIT_ATTENUATION_SETUP 0
`define AWC_BIT_REFERENCE_BUFFER_ENABLE 0
`define AWC_BIT_BIAS 1
`define AWC_BIT_TEMP 2
`define AWC_BIT_REFERENCE_SOURCE_SELECT 3
`define AWC_BIT_REFERENCE_LEVEL_SELECT 4
`define AWC_SC_LSB 3
`define AWC_SC_MSB 7
`endif

//--- logic/awc_pkg.sv
package awc_pkg;
  typedef enum logic [1:0] {
    AWC_IDLE = 2'b00,
    AWC_START = 2'b01,
    AWC_SAR = 2'b10,
    AWC_FINISH = 2'b11
  } awc_state_t;
endpackage

//--- logic/awc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "awc_defs.svh"
// Notes on behaviour
// - Compare each stored word against limits automatically.
// - Match flag lives in control register, pollable.
// - Limits are 16-bit high/low byte pairs.
// - Limit ordering alone picks inside or outside.
// - Inside: word above greater, below less.
// - Outside: word below lower or above upper.
// - Greater-than high byte resets all ones.
// - Setup low code selects unity or half gain.
// - Conversion is 13 SAR clocks plus 2 fast.
// - Source select: pin when 0, supply when 1.
// - Bias enable ORs software bit with users.
// - Level bit picks 1.5 V or 2.25 V.
// - Sensor enable switches the temperature sensor.
// - Stored word justified by justify bit.
// - Unused data bits of a converted word read as zero.
module awc_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic conv_trigger,
  input wire logic [11:0] sar_result,
  input wire logic osc_enabled,
  output logic sar_clk_en,
  output logic window_match_flag,
  output logic conv_done_flag,
  output logic half_gain_select,
  output logic reference_source_select,
  output logic reference_level_select,
  output logic reference_buffer_enable,
  output logic ref_pin_drive,
  output logic temp_sensor_enable,
  output logic bias_generator_enable
);
  import awc_pkg::*;

  // ==========================================================
  // Register file.
  logic [7:0] converter_control, next_converter_control;
  logic [7:0] converter_config, next_converter_config;
  logic [7:0] window_upper_limit_high, next_window_upper_limit_high;
  logic [7:0] window_upper_limit_low, next_window_upper_limit_low;
  logic [7:0] window_lower_limit_high, next_window_lower_limit_high;
  logic [7:0] window_lower_limit_low, next_window_lower_limit_low;
  logic [7:0] reference_control, next_reference_control;
  logic [15:0] conv_word, next_conv_word;
  logic half_gain, next_half_gain;
  logic [15:0] upper_limit, lower_limit;
  logic [15:0] new_word;
  logic word_store, match, start_req;
  logic [1:0] trig_sync;
  awc_state_t state, next_state;

  assign upper_limit = {window_upper_limit_high, window_upper_limit_low};
  assign lower_limit = {window_lower_limit_high, window_lower_limit_low};
  // Justification of the stored word; unused bits are zero.
  assign new_word = converter_control[`AWC_BIT_LJ] ?
    {sar_result, 4'h0} : {4'h0, sar_result};
  // Inside when less-than exceeds greater-than, else outside.
  always_comb begin
    if (lower_limit > upper_limit) begin
      match = (new_word > upper_limit) && (new_word < lower_limit);
    end else begin
      match = (new_word < lower_limit) ||
        (new_word > upper_limit);
    end
  end

  // ==========================================================
  // Register writes and hardware flag updates.
  logic wr_ctrl;
  assign wr_ctrl = sfr_wr && (sfr_addr == `AWC_ADDR_CTRL);
  always_comb begin
    next_converter_control = converter_control;
    next_converter_config = converter_config;
    next_reference_control = reference_control;
    next_conv_word = conv_word;
    if (sfr_wr) begin
      case (sfr_addr)
        `AWC_ADDR_CTRL: begin
          next_converter_control = sfr_wdata;
          next_converter_control[`AWC_BIT_BUSY] = 1'b0;
        end
        `AWC_ADDR_CFG: next_converter_config = sfr_wdata;
        `AWC_ADDR_REF: next_reference_control = sfr_wdata & `AWC_REF_MASK;
        `AWC_ADDR_DATAH: begin
          next_conv_word[15:8] = sfr_wdata;
        end
        `AWC_ADDR_DATAL: begin
          next_conv_word[7:0] = sfr_wdata;
        end
        default: begin
        end
      endcase
    end
    next_converter_control[`AWC_BIT_BUSY] = start_req ||
      (state != AWC_IDLE && !word_store);
    if (word_store) begin
      next_conv_word = new_word;
      next_converter_control[`AWC_BIT_DONE] = 1'b1;
      if (match) begin
        next_converter_control[`AWC_BIT_WIN] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_control <= `AWC_RST_CTRL;
      converter_config <= `AWC_RST_CFG;
      reference_control <= `AWC_RST_REF;
      conv_word <= 16'h0000;
    end else begin
      converter_control <= next_converter_control;
      converter_config <= next_converter_config;
      reference_control <= next_reference_control;
      conv_word <= next_conv_word;
    end
  end

  // ==========================================================
  // Window limit registers.
  always_comb begin
    next_window_upper_limit_high = window_upper_limit_high;
    next_window_upper_limit_low = window_upper_limit_low;
    next_window_lower_limit_high = window_lower_limit_high;
    next_window_lower_limit_low = window_lower_limit_low;
    if (sfr_wr) begin
      case (sfr_addr)
        `AWC_ADDR_GTH: begin
          next_window_upper_limit_high = sfr_wdata;
        end
        `AWC_ADDR_GTL: begin
          next_window_upper_limit_low = sfr_wdata;
        end
        `AWC_ADDR_LTH: begin
          next_window_lower_limit_high = sfr_wdata;
        end
        `AWC_ADDR_LTL: begin
          next_window_lower_limit_low = sfr_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      window_upper_limit_high <= `AWC_RST_GTH;
      window_upper_limit_low <= `AWC_RST_GTL;
      window_lower_limit_high <= `AWC_RST_LTH;
      window_lower_limit_low <= `AWC_RST_LTL;
    end else begin
      window_upper_limit_high <= next_window_upper_limit_high;
      window_upper_limit_low <= next_window_upper_limit_low;
      window_lower_limit_high <= next_window_lower_limit_high;
      window_lower_limit_low <= next_window_lower_limit_low;
    end
  end

  // ==========================================================
  // Gain selection sequence.
  logic gain_armed;
  // A code counts only while setup is set and the high byte is primed.
  assign gain_armed = converter_config[`AWC_BIT_ATTENUATION_SETUP] &&
    (conv_word[15:8] == `AWC_ATTENUATION_SETUP_HI);
  always_comb begin
    next_half_gain = half_gain;
    if (sfr_wr && sfr_addr == `AWC_ADDR_DATAL && gain_armed) begin
      if (sfr_wdata == `AWC_GAIN_UNITY) begin
        next_half_gain = 1'b0;
      end else if (sfr_wdata == `AWC_GAIN_HALF) begin
        next_half_gain = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_gain <= 1'b0;
    end else begin
      half_gain <= next_half_gain;
    end
  end

  // ==========================================================
  // Conversion sequencer.
  logic [4:0] sc_div, next_sc_div;
  logic [4:0] cnt, next_cnt;
  logic sar_tick;
  logic trig_q, next_trig_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_sync <= 2'b00;
    end else begin
      trig_sync <= {trig_sync[0], conv_trigger};
    end
  end

  assign start_req = converter_control[`AWC_BIT_EN] && state == AWC_IDLE &&
    ((wr_ctrl && sfr_wdata[`AWC_BIT_BUSY]) || (trig_sync[1] && !trig_q));
  assign sar_tick = (sc_div ==
    converter_config[`AWC_SC_MSB:`AWC_SC_LSB]);
  assign word_store = (state == AWC_FINISH) &&
    (cnt == `AWC_FAST_EXTRA - 5'h01);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_trig_q = trig_sync[1];
    next_sc_div = sar_tick ? 5'h00 : sc_div + 5'h01;
    case (state)
      AWC_IDLE: begin
        next_sc_div = 5'h00;
        if (start_req) begin
          next_state = AWC_START;
          next_cnt = 5'h00;
        end
      end
      AWC_START: begin
        next_state = AWC_SAR;
        next_cnt = 5'h00;
        next_sc_div = 5'h00;
      end
      AWC_SAR: begin
        if (sar_tick) begin
          next_cnt = cnt + 5'h01;
          if (cnt == `AWC_SAR_CYCLES - 5'h01) begin
            next_state = AWC_FINISH;
            next_cnt = 5'h00;
          end
        end
      end
      AWC_FINISH: begin
        next_cnt = cnt + 5'h01;
        if (word_store) begin
          next_state = AWC_IDLE;
        end
      end
      default: next_state = AWC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= AWC_IDLE;
      cnt <= 5'h00;
      sc_div <= 5'h00;
      trig_q <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sc_div <= next_sc_div;
      trig_q <= next_trig_q;
    end
  end

  // ==========================================================
  // Read mux and analog controls.
  always_comb begin
    case (sfr_addr)
      `AWC_ADDR_CTRL: sfr_rdata = converter_control;
      `AWC_ADDR_CFG: sfr_rdata = converter_config;
      `AWC_ADDR_DATAH: sfr_rdata = conv_word[15:8];
      `AWC_ADDR_DATAL: sfr_rdata = conv_word[7:0];
      `AWC_ADDR_GTH: sfr_rdata = window_upper_limit_high;
      `AWC_ADDR_GTL: sfr_rdata = window_upper_limit_low;
      `AWC_ADDR_LTH: sfr_rdata = window_lower_limit_high;
      `AWC_ADDR_LTL: sfr_rdata = window_lower_limit_low;
      `AWC_ADDR_REF: sfr_rdata = reference_control;
      default: sfr_rdata = 8'h00;
    endcase
  end

  assign sar_clk_en = (state == AWC_SAR) && sar_tick;
  assign window_match_flag = converter_control[`AWC_BIT_WIN];
  assign conv_done_flag = converter_control[`AWC_BIT_DONE];
  assign half_gain_select = half_gain;
  assign reference_source_select =
    reference_control[`AWC_BIT_REFERENCE_SOURCE_SELECT];
  assign reference_level_select =
    reference_control[`AWC_BIT_REFERENCE_LEVEL_SELECT];
  assign reference_buffer_enable =
    reference_control[`AWC_BIT_REFERENCE_BUFFER_ENABLE];
  assign ref_pin_drive = reference_control[`AWC_BIT_REFERENCE_BUFFER_ENABLE];
  assign temp_sensor_enable =
    reference_control[`AWC_BIT_TEMP];
  assign bias_generator_enable = reference_control[`AWC_BIT_BIAS] ||
    converter_control[`AWC_BIT_EN] ||
    reference_control[`AWC_BIT_TEMP] || osc_enabled;
endmodule // awc_top
`default_nettype wire

//--- verification/adc_window_compare_refctl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "awc_defs.svh"
// ====================================================
// Testbench for window compare and reference control.
module adc_window_compare_refctl_test;
  logic ref_clk = 1'b0;
  logic rst_n, sfr_wr, sfr_rd, conv_trigger, osc_enabled;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, r;
  logic [11:0] sar_result;
  logic sar_clk_en, window_match_flag, conv_done_flag, half_gain_select;
  logic reference_source_select, reference_level_select, ref_pin_drive;
  logic reference_buffer_enable, temp_sensor_enable, bias_generator_enable;
  logic [11:0] corner [6] = '{12'h100, 12'h101, 12'h1ff, 12'h200, 12'h0ff,
    12'h201};
  int fails, checks_done, sc;
  always #2.5 ref_clk = ~ref_clk;
  awc_top dut (.ref_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .conv_trigger, .sar_result, .osc_enabled, .sar_clk_en,
    .window_match_flag, .conv_done_flag, .half_gain_select,
    .reference_source_select, .reference_level_select,
    .reference_buffer_enable, .ref_pin_drive, .temp_sensor_enable,
    .bias_generator_enable);
  // ====================================================
  // Bus tasks and expectations.
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    sfr_wr = 1'b0;
  endtask
  task rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    #1;
    sfr_addr = a;
    #1;
    check(16'(sfr_rdata), 16'(exp));
  endtask
  function logic exp_win(logic [15:0] d, logic [15:0] lt, logic [15:0] gt);
    return (lt > gt) ? (d > gt && d < lt) : (d < lt || d > gt);
  endfunction
  function int exp_len(int s);
    return 3 + 13 * (s + 1);
  endfunction
  task conv(input logic [11:0] res, input logic lj, input logic [15:0] lt,
      input logic [15:0] gt, input logic trig);
    logic [15:0] w;
    logic e;
    int n;
    w = lj ? {res, 4'h0} : {4'h0, res};
    e = exp_win(w, lt, gt);
    wr(`AWC_ADDR_CFG, {5'(sc), 3'b000});
    wr(`AWC_ADDR_GTH, gt[15:8]);
    wr(`AWC_ADDR_GTL, gt[7:0]);
    wr(`AWC_ADDR_LTH, lt[15:8]);
    wr(`AWC_ADDR_LTL, lt[7:0]);
    wr(`AWC_ADDR_CTRL, {5'h10, lj, 2'b00});
    sar_result = res;
    if (trig) conv_trigger = 1'b1;
    else wr(`AWC_ADDR_CTRL, {5'h12, lj, 2'b00});
    n = 0;
    while (!conv_done_flag && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    conv_trigger = 1'b0;
    check(16'(conv_done_flag), 16'h0001);
    if (!trig) check(16'(n), 16'(exp_len(sc)));
    check(16'(bias_generator_enable), 16'h0001);
    rc(`AWC_ADDR_DATAH, w[15:8]);
    rc(`AWC_ADDR_DATAL, w[7:0]);
    check(16'(window_match_flag), 16'(e));
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ====================================================
  // Main sequence and watchdog.
  initial begin
    {rst_n, sfr_wr, sfr_rd, conv_trigger, osc_enabled} = 5'h00;
    {sfr_addr, sfr_wdata, sar_result} = 28'h0;
    fails = 0;
    sc = 0;
    checks_done = 0;
    void'($urandom(37751));
    repeat (6) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    sfr_rd = 1'b1;
    rc(`AWC_ADDR_GTH, 8'hff);
    rc(`AWC_ADDR_REF, 8'h00);
    rc(8'h00, 8'h00);
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 8'hff : 8'($urandom);
      wr(`AWC_ADDR_REF, r);
      osc_enabled = 1'($urandom);
      rc(`AWC_ADDR_REF, r & 8'h3f);
      check(16'({reference_source_select, reference_level_select,
        reference_buffer_enable, ref_pin_drive, temp_sensor_enable}),
        16'({r[3], r[4], r[0], r[0], r[2]}));
      check(16'(bias_generator_enable),
        16'(r[1] | r[2] | osc_enabled));
    end
    wr(`AWC_ADDR_REF, 8'h00);
    osc_enabled = 1'b0;
    for (int i = 0; i < 2; i++) begin
      wr(`AWC_ADDR_CFG, 8'h01);
      wr(`AWC_ADDR_DATAH, `AWC_ATTENUATION_SETUP_HI);
      wr(`AWC_ADDR_DATAL, i ? `AWC_GAIN_HALF : `AWC_GAIN_UNITY);
      wr(`AWC_ADDR_CFG, 8'h00);
      check(16'(half_gain_select), 16'(i));
    end
    wr(`AWC_ADDR_DATAL, `AWC_GAIN_UNITY);
    check(16'(half_gain_select), 16'h0001);
    wr(`AWC_ADDR_CFG, 8'h01);
    wr(`AWC_ADDR_DATAL, 8'h55);
    wr(`AWC_ADDR_CFG, 8'h00);
    check(16'(half_gain_select), 16'h0001);
    foreach (corner[i]) begin
      conv(corner[i], 1'b0, 16'h0200, 16'h0100, 1'b0);
      conv(corner[i], 1'b0, 16'h0100, 16'h0200, 1'b0);
    end
    conv(12'h100, 1'b0, 16'h0100, 16'h0100, 1'b1);
    repeat (10) begin
      sc = $urandom % 4;
      conv(12'($urandom), 1'($urandom), 16'($urandom),
        16'($urandom), 1'($urandom));
    end
    give_verdict();
  end
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
endmodule // adc_window_compare_refctl_test
`default_nettype wire

//--- verification/awc_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "awc_defs.svh"
// ====================================================
// Checker for window, conversion and reference outputs.
module awc_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic osc_enabled,
  input wire logic sar_clk_en,
  input wire logic window_match_flag,
  input wire logic conv_done_flag,
  input wire logic reference_source_select,
  input wire logic ref_pin_drive,
  input wire logic reference_buffer_enable,
  input wire logic temp_sensor_enable,
  input wire logic bias_generator_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] ticks;
  logic [4:0] next_ticks;
  logic done_q;
  logic next_done_q;
  always_comb begin
    next_done_q = conv_done_flag;
    next_ticks = ticks + {4'h0, sar_clk_en};
    if (conv_done_flag && !done_q) begin
      next_ticks = 5'h00;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ticks <= 5'h00;
      done_q <= 1'b0;
    end else begin
      ticks <= next_ticks;
      done_q <= next_done_q;
    end
  end
  sequence gth_write;
    sfr_wr && sfr_addr == `AWC_ADDR_GTH;
  endsequence
  sequence gth_read;
    !sfr_wr && sfr_addr == `AWC_ADDR_GTH;
  endsequence
  gth_readback_a: assert property (
    gth_write ##1 gth_read |-> sfr_rdata == $past(sfr_wdata))
    else $error("limit high byte readback wrong");
  win_with_done_a: assert property (
    $rose(window_match_flag) && !$past(sfr_wr) |-> conv_done_flag)
    else $error("match flag set without a stored word");
  flag_read_a: assert property (sfr_addr == `AWC_ADDR_CTRL |->
    sfr_rdata[`AWC_BIT_WIN] == window_match_flag &&
    sfr_rdata[`AWC_BIT_DONE] == conv_done_flag)
    else $error("flags not readable in control");
  ref_write_a: assert property (
    sfr_wr && sfr_addr == `AWC_ADDR_REF |=>
    reference_source_select == $past(sfr_wdata[3]) &&
    temp_sensor_enable == $past(sfr_wdata[2]))
    else $error("reference bits not taken");
  ref_reserved_a: assert property (
    sfr_addr == `AWC_ADDR_REF |-> sfr_rdata[7:6] == 2'b00)
    else $error("reserved reference bits not zero");
  pin_drive_a: assert property (
    sfr_wr && sfr_addr == `AWC_ADDR_REF |=>
    ref_pin_drive == $past(sfr_wdata[`AWC_BIT_REFERENCE_BUFFER_ENABLE]) &&
    reference_buffer_enable == $past(sfr_wdata[`AWC_BIT_REFERENCE_BUFFER_ENABLE]))
    else $error("buffer enable or pin drive not taken");
  bias_force_a: assert property (
    osc_enabled || temp_sensor_enable |-> bias_generator_enable)
    else $error("bias not forced on");
  conv_len_a: assert property (
    conv_done_flag && !done_q |-> ticks == `AWC_SAR_CYCLES)
    else $error("wrong count of converter clocks");
endmodule // awc_chk
bind awc_top awc_chk u_chk (.ref_clk, .rst_n, .sfr_addr, .sfr_wr,
  .sfr_wdata, .sfr_rdata, .osc_enabled, .sar_clk_en, .window_match_flag,
  .conv_done_flag, .reference_source_select, .ref_pin_drive,
  .reference_buffer_enable, .temp_sensor_enable, .bias_generator_enable);
`default_nettype wire
